// ==== hdl/mrb_pkg.sv ====
package mrb_pkg;

  // Message RAM geometry
  localparam int RAM_WORDS = 2048;
  localparam int ADDR_W = 11;
  localparam int BUF_IDX_W = 7;
  localparam int IDX_W = 8;
  localparam int PAYLEN_W = 7;
  localparam int DWORD_W = 7;
  localparam int STAGE_DATA_WORDS = 64;
  localparam int STAGE_IDX_W = 6;
  localparam int HDR_WORDS = 4;
  localparam int HDR_SHIFT = 2;

  // Header field placement
  localparam logic [1:0] PAYLEN_WORD = 2'h1;
  localparam logic [1:0] OFFSET_WORD = 2'h2;
  localparam logic [1:0] HDR_LAST_WORD = 2'h3;
  localparam int PAYLEN_MSB = 6;
  localparam int OFFSET_MSB = 10;

  // Reset values and special codes
  localparam logic [5:0] STATE_CODE_CONFIG = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_UNUSED = 8'h80;
  localparam logic [BUF_IDX_W-1:0] LAST_IDX_RST = 7'h00;
  localparam logic [PAYLEN_W-1:0] STATIC_WORDS_RST = 7'h00;
  localparam logic [1:0] HALF_BOTH = 2'h3;
  localparam logic [1:0] HALF_LOW = 2'h1;

  typedef struct packed {
    logic [BUF_IDX_W-1:0] last_configured_buffer_index;
    logic [IDX_W-1:0] first_dynamic_buffer_index;
    logic [IDX_W-1:0] first_fifo_buffer_index;
    logic [PAYLEN_W-1:0] static_payload_words;
  } mrb_layout_cfg_t;

  typedef enum logic [1:0] {
    KIND_STATIC = 2'b00,
    KIND_DYNAMIC = 2'b01,
    KIND_FIFO = 2'b10,
    KIND_UNCONF = 2'b11
  } mrb_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_XHDR = 3'b001,
    S_XDAT = 3'b010,
    S_RPLC = 3'b011,
    S_RDP = 3'b100,
    S_HOLD = 3'b101,
    S_ACC = 3'b110,
    S_RDAT = 3'b111
  } mrb_state_t;

endpackage

// ==== hdl/mrb_msg_ram.sv ====
`timescale 1ns/1ps
module mrb_msg_ram
  import mrb_pkg::*;
(
  input wire logic clk_i, // controller clock
  input wire logic [ADDR_W-1:0] addr_i, // word address
  input wire logic we_i, // write strobe
  input wire logic [1:0] half_en_i, // 16-bit half enables
  input wire logic [31:0] wdata_i, // write word
  output logic [31:0] rdata_o // read word, one cycle after address
);

  logic [31:0] mem [RAM_WORDS];

  always_ff @(posedge clk_i) begin
    if (we_i && half_en_i[0]) begin
      mem[addr_i][15:0] <= wdata_i[15:0];
    end
    if (we_i && half_en_i[1]) begin
      mem[addr_i][31:16] <= wdata_i[31:16];
    end
    rdata_o <= mem[addr_i];
  end

endmodule

// ==== hdl/mrb_buffer_layout.sv ====
// What this block does
// - Payload length runs 0 to 254 bytes, counted in 2-byte words.
// - Each buffer has a 16-byte header plus a separately located data section.
// - Host header and data go to RAM only through the input staging buffer.
// - Data section start comes from the offset field in the buffer header.
// - Offset is 11 bits, byte address divided by four, zero is buffer 0 header.
// - Offsets are not checked; shared data addresses still get stored.
// - Frame stores into the header region are blocked, dropped and flagged.
// - Upper half of the last word of an odd payload is inaccessible.
// - Message RAM is 8KB and holds 1 to 128 buffers.
// - Layout configuration writes only take effect in config state.
`timescale 1ns/1ps
module mrb_buffer_layout
  import mrb_pkg::*;
(
  input wire logic clk_i, // 20 MHz controller clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [5:0] protocol_state_code_i, // current protocol state code
  input wire logic cfg_wr_i, // layout configuration write strobe
  input wire mrb_layout_cfg_t cfg_i, // layout configuration value
  output mrb_layout_cfg_t cfg_o, // layout configuration in force
  input wire logic hdr_stage_wr_i, // header staging write strobe
  input wire logic [1:0] hdr_stage_idx_i, // header staging word index
  input wire logic [31:0] hdr_stage_data_i, // header staging word
  input wire logic dat_stage_wr_i, // data staging write strobe
  input wire logic [STAGE_IDX_W-1:0] dat_stage_idx_i, // data staging word index
  input wire logic [31:0] dat_stage_data_i, // data staging word
  input wire logic xfer_req_i, // move staging contents into a buffer
  input wire logic [BUF_IDX_W-1:0] xfer_buf_i, // target buffer of the move
  output logic xfer_ready_o, // move request taken this cycle
  output logic xfer_done_o, // move finished, one-cycle pulse
  input wire logic store_req_i, // frame data store request
  input wire logic [BUF_IDX_W-1:0] store_buf_i, // buffer receiving frame data
  input wire logic [DWORD_W-1:0] store_word_i, // RAM word within the data section
  input wire logic [31:0] store_data_i, // two payload words
  output logic store_ready_o, // store request taken this cycle
  output logic store_done_o, // store finished or dropped, one-cycle pulse
  input wire logic rd_req_i, // payload read request
  input wire logic [BUF_IDX_W-1:0] rd_buf_i, // buffer to read
  input wire logic [DWORD_W-1:0] rd_word_i, // RAM word within the data section
  output logic rd_ready_o, // read request taken this cycle
  output logic rd_valid_o, // read data valid, one-cycle pulse
  output logic [31:0] rd_data_o, // read payload word pair
  output mrb_kind_t rd_kind_o, // region of the buffer read
  output logic header_write_attempt_flag_o, // sticky header protection hit
  input wire logic flag_clr_i, // clears the header protection flag
  output logic busy_o // an access is in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Buffer n, header word k sits at RAM word 4n+k
  function automatic logic [ADDR_W-1:0] hdr_addr(input logic [BUF_IDX_W-1:0] n,
                                                 input logic [1:0] k);
    hdr_addr = ADDR_W'({n, k});
  endfunction

  // length in 2-byte words
  // Payload words packed two per RAM word
  function automatic logic [DWORD_W-1:0] ram_words(input logic [PAYLEN_W-1:0] len);
    logic [PAYLEN_W:0] sum;
    sum = {1'b0, len} + 8'h01;
    ram_words = sum[PAYLEN_W:1];
  endfunction

  function automatic mrb_kind_t kind_of(input logic [BUF_IDX_W-1:0] n,
                                        input mrb_layout_cfg_t c);
    if (n > c.last_configured_buffer_index) begin
      kind_of = KIND_UNCONF;
    end else if ({1'b0, n} >= c.first_fifo_buffer_index) begin
      kind_of = KIND_FIFO;
    end else if ({1'b0, n} >= c.first_dynamic_buffer_index) begin
      kind_of = KIND_DYNAMIC;
    end else begin
      kind_of = KIND_STATIC;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Layout configuration and staging registers

  mrb_layout_cfg_t cfg_q, cfg_d;
  logic [31:0] hstage_q [HDR_WORDS];
  logic [31:0] hstage_d [HDR_WORDS];
  logic [31:0] dstage_q [STAGE_DATA_WORDS];
  logic [31:0] dstage_d [STAGE_DATA_WORDS];

  always_comb begin
    cfg_d = cfg_q;
    hstage_d = hstage_q;
    dstage_d = dstage_q;
    if (cfg_wr_i && protocol_state_code_i == STATE_CODE_CONFIG) begin
      cfg_d = cfg_i;
    end
    if (hdr_stage_wr_i) begin
      hstage_d[hdr_stage_idx_i] = hdr_stage_data_i;
    end
    if (dat_stage_wr_i) begin
      dstage_d[dat_stage_idx_i] = dat_stage_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= '{LAST_IDX_RST, IDX_UNUSED, IDX_UNUSED, STATIC_WORDS_RST};
      for (int i = 0; i < HDR_WORDS; i++) begin
        hstage_q[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < STAGE_DATA_WORDS; i++) begin
        dstage_q[i] <= 32'h0000_0000;
      end
    end else begin
      cfg_q <= cfg_d;
      hstage_q <= hstage_d;
      dstage_q <= dstage_d;
    end
  end

  assign cfg_o = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Message RAM access sequencer

  mrb_state_t st_q, st_d;
  logic [DWORD_W-1:0] cnt_q, cnt_d;
  logic [BUF_IDX_W-1:0] buf_q, buf_d;
  logic [DWORD_W-1:0] word_q, word_d;
  logic [31:0] wdat_q, wdat_d;
  logic is_store_q, is_store_d;
  logic [PAYLEN_W-1:0] len_q, len_d;
  logic [ADDR_W-1:0] ofs_q, ofs_d;
  logic flag_q, flag_d;
  logic xdone_q, xdone_d;
  logic sdone_q, sdone_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  mrb_kind_t kind_q, kind_d;
  logic flag_set;
  logic [ADDR_W-1:0] ram_addr;
  logic ram_we;
  logic [1:0] ram_half;
  logic [31:0] ram_wdata;
  logic [31:0] ram_rdata;
  logic [PAYLEN_W-1:0] stage_len;
  logic [ADDR_W-1:0] stage_ofs;
  logic [DWORD_W-1:0] stage_words;
  logic [DWORD_W-1:0] buf_words;
  logic [ADDR_W-1:0] acc_addr;
  logic [ADDR_W-1:0] hdr_end;
  logic last_odd;

  assign stage_len = hstage_q[PAYLEN_WORD][PAYLEN_MSB:0];
  assign stage_ofs = hstage_q[OFFSET_WORD][OFFSET_MSB:0];
  assign stage_words = ram_words(stage_len);
  assign buf_words = ram_words(len_q);
  // offset is a RAM word index
  assign acc_addr = ofs_q + ADDR_W'(word_q);
  // First word past every header
  assign hdr_end = ADDR_W'({{1'b0, cfg_q.last_configured_buffer_index} + 8'h01, 2'b00});
  assign last_odd = len_q[0] && (word_q == buf_words - 7'h01);

  // Moves win over frame stores, which win over reads
  assign xfer_ready_o = (st_q == S_IDLE);
  assign store_ready_o = (st_q == S_IDLE) && !xfer_req_i;
  assign rd_ready_o = (st_q == S_IDLE) && !xfer_req_i && !store_req_i;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    buf_d = buf_q;
    word_d = word_q;
    wdat_d = wdat_q;
    is_store_d = is_store_q;
    len_d = len_q;
    ofs_d = ofs_q;
    xdone_d = 1'b0;
    sdone_d = 1'b0;
    rvalid_d = 1'b0;
    rdata_d = rdata_q;
    kind_d = kind_q;
    flag_set = 1'b0;
    ram_addr = '0;
    ram_we = 1'b0;
    ram_half = HALF_BOTH;
    ram_wdata = 32'h0000_0000;
    case (st_q)
      S_IDLE: begin
        cnt_d = '0;
        if (xfer_req_i) begin
          buf_d = xfer_buf_i;
          st_d = S_XHDR;
        end else if (store_req_i) begin
          buf_d = store_buf_i;
          word_d = store_word_i;
          wdat_d = store_data_i;
          is_store_d = 1'b1;
          st_d = S_RPLC;
        end else if (rd_req_i) begin
          buf_d = rd_buf_i;
          word_d = rd_word_i;
          is_store_d = 1'b0;
          st_d = S_RPLC;
        end
      end
      S_XHDR: begin
        ram_addr = hdr_addr(buf_q, cnt_q[1:0]);
        ram_we = 1'b1;
        ram_wdata = hstage_q[cnt_q[1:0]];
        cnt_d = cnt_q + 7'h01;
        if (cnt_q[1:0] == HDR_LAST_WORD) begin
          cnt_d = '0;
          if (stage_words == '0) begin
            xdone_d = 1'b1;
            st_d = S_IDLE;
          end else begin
            st_d = S_XDAT;
          end
        end
      end
      S_XDAT: begin
        // two payload words per RAM word
        ram_addr = stage_ofs + ADDR_W'(cnt_q);
        ram_we = 1'b1;
        ram_wdata = dstage_q[cnt_q[STAGE_IDX_W-1:0]];
        if (stage_len[0] && cnt_q == stage_words - 7'h01) begin
          ram_half = HALF_LOW;
        end
        cnt_d = cnt_q + 7'h01;
        if (cnt_q == stage_words - 7'h01) begin
          xdone_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_RPLC: begin
        ram_addr = hdr_addr(buf_q, PAYLEN_WORD);
        st_d = S_RDP;
      end
      S_RDP: begin
        ram_addr = hdr_addr(buf_q, OFFSET_WORD);
        len_d = ram_rdata[PAYLEN_MSB:0];
        st_d = S_HOLD;
      end
      S_HOLD: begin
        ofs_d = ram_rdata[OFFSET_MSB:0];
        st_d = S_ACC;
      end
      S_ACC: begin
        kind_d = kind_of(buf_q, cfg_q);
        st_d = S_IDLE;
        if (is_store_q) begin
          sdone_d = 1'b1;
          if (word_q < buf_words) begin
            if (acc_addr < hdr_end) begin
              flag_set = 1'b1;
            end else begin
              ram_addr = acc_addr;
              ram_we = 1'b1;
              ram_wdata = wdat_q;
              ram_half = last_odd ? HALF_LOW : HALF_BOTH;
            end
          end
        end else if (word_q < buf_words) begin
          ram_addr = acc_addr;
          st_d = S_RDAT;
        end else begin
          rdata_d = 32'h0000_0000;
          rvalid_d = 1'b1;
        end
      end
      S_RDAT: begin
        rdata_d = last_odd ? {16'h0000, ram_rdata[15:0]} : ram_rdata;
        rvalid_d = 1'b1;
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle
    flag_d = (flag_q && !flag_clr_i) || flag_set;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      buf_q <= '0;
      word_q <= '0;
      wdat_q <= 32'h0000_0000;
      is_store_q <= 1'b0;
      len_q <= '0;
      ofs_q <= '0;
      flag_q <= 1'b0;
      xdone_q <= 1'b0;
      sdone_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      kind_q <= KIND_STATIC;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      buf_q <= buf_d;
      word_q <= word_d;
      wdat_q <= wdat_d;
      is_store_q <= is_store_d;
      len_q <= len_d;
      ofs_q <= ofs_d;
      flag_q <= flag_d;
      xdone_q <= xdone_d;
      sdone_q <= sdone_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      kind_q <= kind_d;
    end
  end

  assign xfer_done_o = xdone_q;
  assign store_done_o = sdone_q;
  assign rd_valid_o = rvalid_q;
  assign rd_data_o = rdata_q;
  assign rd_kind_o = kind_q;
  assign header_write_attempt_flag_o = flag_q;
  assign busy_o = (st_q != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Message RAM, 8KB as 2048 words

  mrb_msg_ram u_ram (
    .clk_i(clk_i),
    .addr_i(ram_addr),
    .we_i(ram_we),
    .half_en_i(ram_half),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

endmodule

// ==== test/mrb_buffer_layout_properties.sv ====
`timescale 1ns/1ps
module mrb_props
  import mrb_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [5:0] protocol_state_code_i, // state code
  input wire logic cfg_wr_i, // layout strobe
  input wire mrb_layout_cfg_t cfg_i, // layout value
  input wire mrb_layout_cfg_t cfg_o, // layout in force
  input wire logic xfer_req_i, // move request
  input wire logic xfer_ready_o, // move taken
  input wire logic xfer_done_o, // move done
  input wire logic store_req_i, // store request
  input wire logic store_ready_o, // store taken
  input wire logic store_done_o, // store done
  input wire logic rd_req_i, // read request
  input wire logic rd_ready_o, // read taken
  input wire logic rd_valid_o, // read valid
  input wire logic header_write_attempt_flag_o, // protection flag
  input wire logic flag_clr_i, // flag clear
  input wire logic busy_o // busy
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_CFG_TAKE: assert property (cfg_wr_i && protocol_state_code_i == STATE_CODE_CONFIG
    |=> cfg_o == $past(cfg_i)) else $error("layout write not applied");
  AST_CFG_HOLD: assert property (!(cfg_wr_i && protocol_state_code_i == STATE_CODE_CONFIG)
    |=> $stable(cfg_o)) else $error("layout changed without accepted write");
  AST_XFER_DONE: assert property (xfer_req_i && xfer_ready_o
    |-> ##[5:69] xfer_done_o) else $error("move did not finish in time");
  AST_XFER_HDR: assert property (xfer_req_i && xfer_ready_o
    |=> busy_o [*4]) else $error("move shorter than four header words");
  AST_STORE_DONE: assert property (store_req_i && store_ready_o
    |-> ##[5:6] store_done_o) else $error("store did not finish in time");
  AST_RD_VALID: assert property (rd_req_i && rd_ready_o
    |-> ##[5:6] rd_valid_o) else $error("read data late");
  AST_FLAG_CAUSE: assert property ($rose(header_write_attempt_flag_o)
    |-> store_done_o) else $error("flag set without a store");
  AST_FLAG_HOLD: assert property (header_write_attempt_flag_o && !flag_clr_i
    |=> header_write_attempt_flag_o) else $error("flag lost without clear");
  AST_READY_EXCL: assert property (busy_o
    |-> !(xfer_ready_o || store_ready_o || rd_ready_o)) else $error("ready while busy");
endmodule

bind mrb_buffer_layout mrb_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .protocol_state_code_i(protocol_state_code_i), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i),
  .cfg_o(cfg_o), .xfer_req_i(xfer_req_i), .xfer_ready_o(xfer_ready_o),
  .xfer_done_o(xfer_done_o), .store_req_i(store_req_i), .store_ready_o(store_ready_o),
  .store_done_o(store_done_o), .rd_req_i(rd_req_i), .rd_ready_o(rd_ready_o),
  .rd_valid_o(rd_valid_o), .header_write_attempt_flag_o(header_write_attempt_flag_o),
  .flag_clr_i(flag_clr_i), .busy_o(busy_o));

// ==== test/mrb_host_model.sv ====
`timescale 1ns/1ps
module mrb_host_model
  import mrb_pkg::*;
(
  input wire logic clk_i, // controller clock
  input wire logic xfer_ready_i, // move taken
  input wire logic xfer_done_i, // move finished
  output logic cfg_wr_o, // layout strobe
  output mrb_layout_cfg_t cfg_o, // layout value
  output logic hdr_wr_o, // header staging strobe
  output logic [1:0] hdr_idx_o, // header staging index
  output logic [31:0] hdr_data_o, // header staging word
  output logic dat_wr_o, // data staging strobe
  output logic [STAGE_IDX_W-1:0] dat_idx_o, // data staging index
  output logic [31:0] dat_data_o, // data staging word
  output logic xfer_req_o, // move request
  output logic [BUF_IDX_W-1:0] xfer_buf_o // move target
);
  initial begin
    {cfg_wr_o, cfg_o, hdr_wr_o, hdr_idx_o, hdr_data_o} = '0;
    {dat_wr_o, dat_idx_o, dat_data_o, xfer_req_o, xfer_buf_o} = '0;
  end

  task automatic set_layout(input mrb_layout_cfg_t c);
    @(posedge clk_i);
    #1;
    cfg_o = c;
    cfg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    cfg_wr_o = 1'b0;
  endtask

  task automatic load_buffer(input logic [6:0] n, input logic [6:0] len_words,
                             input logic [10:0] ofs, input logic [31:0] base);
    int i;
    @(posedge clk_i);
    #1;
    hdr_wr_o = 1'b1;
    for (i = 0; i < 4; i++) begin
      hdr_idx_o = 2'(i);
      hdr_data_o = (i == 1) ? 32'(len_words) : (i == 2) ? 32'(ofs) : 32'h0;
      @(posedge clk_i);
      #1;
    end
    hdr_wr_o = 1'b0;
    dat_wr_o = 1'b1;
    for (i = 0; i < (int'(len_words) + 1) / 2; i++) begin
      dat_idx_o = 6'(i);
      dat_data_o = base + 32'(i);
      @(posedge clk_i);
      #1;
    end
    dat_wr_o = 1'b0;
    xfer_buf_o = n;
    xfer_req_o = 1'b1;
    while (xfer_ready_i !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i);
    #1;
    xfer_req_o = 1'b0;
    for (i = 0; i < 100 && xfer_done_i !== 1'b1; i++) @(posedge clk_i) #1;
  endtask
endmodule

// ==== test/mrb_buffer_layout_tb.sv ====
`timescale 1ns/1ps
module mrb_buffer_layout_tb;
  import mrb_pkg::*;
  localparam mrb_layout_cfg_t RST_CFG = '{7'h00, 8'h80, 8'h80, 7'h00};
  localparam mrb_layout_cfg_t FIFO_CFG = '{7'h03, 8'h80, 8'h02, 7'h03};
  localparam mrb_layout_cfg_t DYN_CFG = '{7'h03, 8'h01, 8'h80, 7'h03};
  logic clk_i, rst_n_i, cfg_wr, hdr_wr, dat_wr, xfer_req, xfer_ready, xfer_done;
  logic store_req, store_ready, store_done, rd_req, rd_ready, rd_valid, flag, flag_clr, busy;
  logic [5:0] state_code;
  logic [1:0] hdr_idx;
  logic [5:0] dat_idx;
  logic [6:0] xfer_buf, store_buf, store_word, rd_buf, rd_word;
  logic [31:0] hdr_data, dat_data, store_data, rd_data;
  mrb_layout_cfg_t cfg, cfg_out;
  mrb_kind_t rd_kind;
  int mismatches = 0;
  int compares = 0;

  mrb_host_model host_u (.clk_i(clk_i), .xfer_ready_i(xfer_ready), .xfer_done_i(xfer_done),
    .cfg_wr_o(cfg_wr), .cfg_o(cfg), .hdr_wr_o(hdr_wr), .hdr_idx_o(hdr_idx),
    .hdr_data_o(hdr_data), .dat_wr_o(dat_wr), .dat_idx_o(dat_idx), .dat_data_o(dat_data),
    .xfer_req_o(xfer_req), .xfer_buf_o(xfer_buf));
  mrb_buffer_layout dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .protocol_state_code_i(state_code),
    .cfg_wr_i(cfg_wr), .cfg_i(cfg), .cfg_o(cfg_out), .hdr_stage_wr_i(hdr_wr),
    .hdr_stage_idx_i(hdr_idx), .hdr_stage_data_i(hdr_data), .dat_stage_wr_i(dat_wr),
    .dat_stage_idx_i(dat_idx), .dat_stage_data_i(dat_data), .xfer_req_i(xfer_req),
    .xfer_buf_i(xfer_buf), .xfer_ready_o(xfer_ready), .xfer_done_o(xfer_done),
    .store_req_i(store_req), .store_buf_i(store_buf), .store_word_i(store_word),
    .store_data_i(store_data), .store_ready_o(store_ready), .store_done_o(store_done),
    .rd_req_i(rd_req), .rd_buf_i(rd_buf), .rd_word_i(rd_word), .rd_ready_o(rd_ready),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_kind_o(rd_kind),
    .header_write_attempt_flag_o(flag), .flag_clr_i(flag_clr), .busy_o(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Frame side store; hold the request until the edge that sees ready
  task automatic store(input logic [6:0] b, input logic [6:0] w, input logic [31:0] d);
    int i;
    store_buf = b;
    store_word = w;
    store_data = d;
    store_req = 1'b1;
    while (store_ready !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i);
    #1;
    store_req = 1'b0;
    for (i = 0; i < 10 && store_done !== 1'b1; i++) @(posedge clk_i) #1;
    check("store done", 32'(store_done), 32'h1);
  endtask

  task automatic read(input logic [6:0] b, input logic [6:0] w, input logic [31:0] exp,
                      input mrb_kind_t k);
    int i;
    rd_buf = b;
    rd_word = w;
    rd_req = 1'b1;
    while (rd_ready !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i);
    #1;
    rd_req = 1'b0;
    for (i = 0; i < 10 && rd_valid !== 1'b1; i++) @(posedge clk_i) #1;
    check("read data", rd_data, exp);
    check("read kind", 32'(rd_kind), 32'(k));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    #250000;
    mismatches++;
    stop_test();
  end

  initial begin
    {rst_n_i, state_code, store_req, store_buf, store_word, store_data} = '0;
    {rd_req, rd_buf, rd_word, flag_clr} = '0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    check("reset layout", 32'(cfg_out), 32'(RST_CFG));
    host_u.set_layout(FIFO_CFG);
    check("refused layout", 32'(cfg_out), 32'(RST_CFG));
    state_code = STATE_CODE_CONFIG;
    host_u.set_layout(FIFO_CFG);
    check("layout", 32'(cfg_out), 32'(FIFO_CFG));
    // Buffer 3 points into buffer 1's header on purpose; buffer 1 is loaded after it
    host_u.load_buffer(7'h03, 7'h04, 11'h004, 32'hD000_0000);
    host_u.load_buffer(7'h01, 7'h04, 11'h7F8, 32'hB000_0000);
    host_u.load_buffer(7'h02, 7'h03, 11'h010, 32'hC000_0000);
    host_u.load_buffer(7'h00, 7'h03, 11'h010, 32'hA000_0000);
    read(7'h00, 7'h00, 32'hA000_0000, KIND_STATIC);
    read(7'h00, 7'h01, 32'h0000_0001, KIND_STATIC);
    read(7'h00, 7'h02, 32'h0000_0000, KIND_STATIC);
    read(7'h01, 7'h01, 32'hB000_0001, KIND_STATIC);
    read(7'h02, 7'h00, 32'hA000_0000, KIND_FIFO);
    store(7'h02, 7'h00, 32'h5555_AAAA);
    read(7'h00, 7'h00, 32'h5555_AAAA, KIND_STATIC);
    store(7'h00, 7'h02, 32'h0BAD_0BAD);
    check("flag after drop", 32'(flag), 32'h0);
    store(7'h03, 7'h01, 32'hFFFF_FFFF);
    check("flag after hit", 32'(flag), 32'h1);
    read(7'h03, 7'h01, 32'h0000_0004, KIND_FIFO);
    read(7'h01, 7'h01, 32'hB000_0001, KIND_STATIC);
    flag_clr = 1'b1;
    @(posedge clk_i);
    #1;
    flag_clr = 1'b0;
    check("flag cleared", 32'(flag), 32'h0);
    store(7'h00, 7'h01, 32'h1234_5678);
    read(7'h00, 7'h01, 32'h0000_5678, KIND_STATIC);
    host_u.set_layout(DYN_CFG);
    read(7'h01, 7'h00, 32'hB000_0000, KIND_DYNAMIC);
    stop_test();
  end
endmodule
